// file: cpg_edge_filter.v
// input synchroniser, source select, glitch filter and edge detector
`timescale 1ns/1ns
module cpg_edge_filter #(
   parameter W  = 4,
   parameter SW = 2,
   parameter FW = 16
) (
   input  wire          clk,
   input  wire          nrst,
   input  wire [W-1:0]  pins,
   input  wire [SW-1:0] sel,
   input  wire          filt_en,
   input  wire [FW-1:0] min_width,
   output reg           rise,
   output reg           fall
);
   reg  [W-1:0]  sync1;
   reg  [W-1:0]  sync2;
   reg           stable;
   reg           prev;
   reg  [FW-1:0] fcnt;
   wire          raw = sync2[sel];

   // ****************************************
   // two-stage synchroniser on every pin
   // ****************************************
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= {W{1'b0}};
         sync2 <= {W{1'b0}};
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end

   // ****************************************
   // filter, then edge detect
   // ****************************************
   // a new level is accepted only after it held min_width cycles
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stable <= 1'b0;
         prev   <= 1'b0;
         fcnt   <= {FW{1'b0}};
         rise   <= 1'b0;
         fall   <= 1'b0;
      end else begin
         if (!filt_en) begin
            stable <= raw;
            fcnt   <= {FW{1'b0}};
         end else if (raw == stable) begin
            fcnt   <= {FW{1'b0}}; // see R09
         end else if (fcnt + 1'b1 >= min_width) begin
            stable <= raw;
            fcnt   <= {FW{1'b0}};
         end else begin
            fcnt   <= fcnt + 1'b1;
         end
         prev <= stable;
         rise <= stable & ~prev;
         fall <= ~stable & prev;
      end
   end
endmodule

// file: cpg_pins.sv
// trigger and sample clock sources on the pins
`timescale 1ns/1ns
module cpg_pins #(
   parameter N = 4
) (
   output logic [N-1:0] trig,
   output logic [N-1:0] sclk
);
   initial begin
      trig = '0;
      sclk = '0;
   end
   // sources are unrelated to the timebase, so edges land mid-cycle
   task automatic put(input int s, input logic v);
      #7 trig[s] = v;
   endtask
   task automatic glitch(input int s, input int ns);
      #7 trig[s] = ~trig[s];
      #(ns) trig[s] = ~trig[s];
   endtask
   task automatic tick(input int s);
      #7 sclk[s] = 1'b1;
      #200 sclk[s] = 1'b0;
   endtask
endmodule

// file: cpg_properties.sv
// concurrent checks on the generator's ports
`timescale 1ns/1ns
`include "cpg_regs.vh"
module cpg_chk #(
   parameter NPIN = 4
) (
   input wire logic            CLK,
   input wire logic            NRST,
   input wire logic            PSEL,
   input wire logic            PENABLE,
   input wire logic            PWRITE,
   input wire logic [7:0]      PADDR,
   input wire logic [31:0]     PWDATA,
   input wire logic [31:0]     PRDATA,
   input wire logic [NPIN-1:0] PIN_OUT,
   input wire logic [NPIN-1:0] PIN_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   logic [31:0] ctl, hi, lo, dly, hn, ln;
   logic [2:0]  sc;
   logic        run, a1, a2;
   wire         cw  = PSEL && PENABLE && PWRITE && PADDR == `CPG_CTRL_OFS;
   // triggered starts are not tracked, so a start while running must be preceded by a stop
   wire         go  = cw && PWDATA[0] && !PWDATA[5] && !run;
   wire         lvl = |(PIN_OUT & PIN_OE) ^ ctl[2];
   wire         tk  = ctl[11:10] == `CPG_FMT_TICKS && ctl[4:3] != `CPG_MODE_VAR;
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ctl <= '0;
         hi  <= 32'd1;
         lo  <= 32'd1;
         dly <= '0;
      end else if (PSEL && PENABLE && PWRITE) begin
         case (PADDR)
            `CPG_CTRL_OFS:  ctl <= PWDATA;
            `CPG_DELAY_OFS: dly <= PWDATA;
            `CPG_HIGH_OFS:  hi <= PWDATA;
            `CPG_LOW_OFS:   lo <= PWDATA;
            default: ;
         endcase
      end
   end
   // a stop truncates the pulse in flight, so lengths are not judged for a few cycles after it
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         hn  <= '0;
         ln  <= '0;
         sc  <= '0;
         run <= 1'b0;
         a1  <= 1'b0;
         a2  <= 1'b0;
      end else begin
         hn  <= lvl ? hn + 1 : '0;
         ln  <= lvl ? '0 : ln + 1;
         sc  <= cw ? (PWDATA[1] ? 3'd6 : 3'd2) : (sc != 0 ? sc - 1 : sc);
         run <= (cw && PWDATA[1]) ? 1'b0 : (go ? 1'b1 : run);
         a1  <= cw ? 1'b0 : (($rose(lvl) && sc == 0) ? 1'b1 : a1);
         a2  <= cw ? 1'b0 : (($fell(lvl) && a1) ? 1'b1 : a2);
      end
   end
   AST_OE_ONE: assert property ($onehot0(PIN_OE)) else $error("several pins enabled");
   AST_OUT_OE: assert property ((PIN_OUT & ~PIN_OE) == '0) else $error("unselected pin driven");
   AST_MIN_DLY: assert property (go |=> $stable(PIN_OUT) [*4]) else $error("output moved in delay");
   AST_FIRST: assert property (go && dly <= 32'd2 && tk |-> ##4 !lvl ##1 lvl) else $error("late pulse");
   AST_STOP: assert property (cw && PWDATA[1] |-> ##4 !lvl) else $error("stop left output active");
   AST_HIGH: assert property ($fell(lvl) && a1 && tk |-> hn == (hi == 0 ? 32'd1 : hi))
      else $error("active length wrong");
   AST_LOW: assert property ($rose(lvl) && a2 && tk && ctl[4:3] == `CPG_MODE_CONT |-> ln == (lo == 0 ? 32'd1 : lo))
      else $error("idle length wrong");
   AST_CTL_RD: assert property (PSEL && PENABLE && !PWRITE && PADDR == `CPG_CTRL_OFS |-> PRDATA[1:0] == 2'h0)
      else $error("command bits read back");
endmodule
bind cpg_top cpg_chk #(.NPIN(NPIN)) u_chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));

// file: cpg_regs.vh
// register map, field positions, reset values and timing counts of the pulse train generator
`ifndef CPG_REGS_VH
`define CPG_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define CPG_CTRL_OFS        8'h00
`define CPG_DELAY_OFS       8'h04
`define CPG_HIGH_OFS        8'h08
`define CPG_LOW_OFS         8'h0c
`define CPG_COUNT_OFS       8'h10
`define CPG_FILTER_OFS      8'h14
`define CPG_PINSEL_OFS      8'h18
`define CPG_STATUS_OFS      8'h1c
`define CPG_PULSES_OFS      8'h20
`define CPG_BUFLEN_OFS      8'h24
`define CPG_BUFPTR_OFS      8'h28
`define CPG_BUFA_OFS        8'h2c
`define CPG_BUFB_OFS        8'h30

// ****************************************
// control register fields
// ****************************************
`define CPG_START_BIT       0
`define CPG_STOP_BIT        1
`define CPG_IDLE_BIT        2
`define CPG_MODE_LSB        3
`define CPG_TRIGEN_BIT      5
`define CPG_TRIGEDGE_BIT    6
`define CPG_FILTEN_BIT      7
`define CPG_RETRIG_BIT      8
`define CPG_DLYEACH_BIT     9
`define CPG_FMT_LSB         10
`define CPG_BMODE_LSB       12
`define CPG_SCEDGE_BIT      14
`define CPG_TSRC_LSB        15
`define CPG_SSRC_LSB        17
`define CPG_CTRL_MSB        18

// ****************************************
// encodings
// ****************************************
`define CPG_MODE_FINITE     2'h0
`define CPG_MODE_CONT       2'h1
`define CPG_MODE_VAR        2'h2
`define CPG_FMT_TICKS       2'h0
`define CPG_FMT_TIME        2'h1
`define CPG_FMT_FREQ        2'h2
`define CPG_BUF_ONCE        2'h0
`define CPG_BUF_CYCLE       2'h1
`define CPG_BUF_LIVE        2'h2

// ****************************************
// reset values and timing
// ****************************************
`define CPG_CTRL_RST        19'h00000
`define CPG_PINSEL_RST      8'h00
`define CPG_TIMEBASE_HZ     32'd100000000
`define CPG_TICK_NS         32'd10
`define CPG_MIN_DELAY_TICKS 32'd2

`endif

// file: cpg_top.v
// counter pulse train generator with apb register access
// Operation
// R01: output rests at selectable idle level
// R02: delay, then active, then idle, repeated
// R03: all durations counted in timebase ticks
// R04: every pulse of a series identical
// R05: finite mode: exact pulse count, then idle
// R06: continuous mode runs until stopped
// R07: software start or selected trigger edge
// R08: start delay never below two ticks
// R09: optional minimum-width filter on trigger
// R10: retrigger repeats the same series
// R11: delay only first trigger unless delay-each set
// R12: variable mode adopts buffer sample per edge
// R13: finish current pulse before new parameters
// R14: samples as ticks, time or frequency
// R15: buffer once, cycled, or live updated
// R16: output on default or selected pin
// R17: synchronised inputs, intervals at least one tick
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "cpg_regs.vh"
module cpg_top #(
   parameter CW    = 32,
   parameter NSRC  = 4,
   parameter SW    = 2,
   parameter NPIN  = 4,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire            CLK,
   input  wire            NRST,
   input  wire            PSEL,
   input  wire            PENABLE,
   input  wire            PWRITE,
   input  wire [7:0]      PADDR,
   input  wire [31:0]     PWDATA,
   output reg  [31:0]     PRDATA,
   output wire            PREADY,
   output wire            PSLVERR,
   input  wire [NSRC-1:0] TRIG_PIN,
   input  wire [NSRC-1:0] SCLK_PIN,
   output reg  [NPIN-1:0] PIN_OUT,
   output reg  [NPIN-1:0] PIN_OE
);
   localparam [5:0] ST_IDLE  = 6'b000001;
   localparam [5:0] ST_ARM   = 6'b000010;
   localparam [5:0] ST_DLY   = 6'b000100;
   localparam [5:0] ST_ACT   = 6'b001000;
   localparam [5:0] ST_LOW   = 6'b010000;
   localparam [5:0] ST_REARM = 6'b100000;
   localparam [CW-1:0] TB_HZ   = `CPG_TIMEBASE_HZ;
   localparam [CW-1:0] TICK_NS = `CPG_TICK_NS;
   localparam [CW-1:0] MIN_DLY = `CPG_MIN_DELAY_TICKS;

   reg  [`CPG_CTRL_MSB:0] ctrl;
   reg  [CW-1:0]          delay_a;
   reg  [CW-1:0]          high_duration;
   reg  [CW-1:0]          low_duration;
   reg  [CW-1:0]          pulse_total;
   reg  [15:0]            filt_width;
   reg  [7:0]             output_pin_select;
   reg  [AW:0]            buf_len;
   reg  [AW-1:0]          buf_wptr;
   reg  [CW-1:0]          buf_stage;
   reg  [CW-1:0]          buf_a [0:DEPTH-1];
   reg  [CW-1:0]          buf_b [0:DEPTH-1];
   reg                    start_cmd;
   reg                    stop_cmd;
   reg  [5:0]             state;
   reg  [CW-1:0]          cnt;
   reg  [CW-1:0]          pulses;
   reg  [CW-1:0]          cur_idle;
   reg  [CW-1:0]          cur_act;
   reg  [AW:0]            rd_idx;
   reg                    pending;
   reg  [CW-1:0]          next_idle;
   reg  [CW-1:0]          next_act;
   reg  [AW:0]            next_idx;
   reg                    next_stop;
   wire                   t_rise;
   wire                   t_fall;
   wire                   s_rise;
   wire                   s_fall;

   wire       idle_level           = ctrl[`CPG_IDLE_BIT];
   wire [1:0] mode                 = ctrl[`CPG_MODE_LSB+1:`CPG_MODE_LSB];
   wire       trig_en              = ctrl[`CPG_TRIGEN_BIT];
   wire       trigger_filter_enable = ctrl[`CPG_FILTEN_BIT];
   wire       retrig               = ctrl[`CPG_RETRIG_BIT];
   wire       delay_each_retrigger = ctrl[`CPG_DLYEACH_BIT];
   wire [1:0] fmt                  = ctrl[`CPG_FMT_LSB+1:`CPG_FMT_LSB];
   wire [1:0] bmode                = ctrl[`CPG_BMODE_LSB+1:`CPG_BMODE_LSB];
   wire       running              = ~state[0];

   // ****************************************
   // conversion of a sample pair into ticks
   // ****************************************
   // a is idle or frequency, b is active or duty in 1/256 steps
   function [CW-1:0] to_ticks;
      input [1:0]    f;
      input [CW-1:0] a;
      input [CW-1:0] b;
      input          want_act;
      reg   [CW-1:0] period;
      reg   [CW+7:0] prod;
      reg   [CW-1:0] idl;
      reg   [CW-1:0] act;
      begin
         period = {CW{1'b0}};
         prod   = {(CW+8){1'b0}};
         case (f) // see R14
            `CPG_FMT_TIME: begin
               idl = a / TICK_NS; // see R03
               act = b / TICK_NS;
            end
            `CPG_FMT_FREQ: begin
               period = (a == {CW{1'b0}}) ? {CW{1'b0}} : TB_HZ / a;
               prod   = period * b[7:0];
               act    = prod[CW+7:8];
               idl    = period - act;
            end
            default: begin
               idl = a;
               act = b;
            end
         endcase
         to_ticks = want_act ? act : idl;
         if (to_ticks == {CW{1'b0}}) begin
            to_ticks = {{(CW-1){1'b0}}, 1'b1}; // see R17
         end
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'h0) && (a <= `CPG_BUFB_OFS);
      end
   endfunction

   wire [CW-1:0] init_idle = to_ticks(fmt, low_duration, high_duration, 1'b0);
   wire [CW-1:0] init_act  = to_ticks(fmt, low_duration, high_duration, 1'b1);
   wire [CW-1:0] dly_ticks = (delay_a < MIN_DLY) ? MIN_DLY : delay_a; // see R08
   wire [CW-1:0] dly_ld    = dly_ticks - 1'b1;
   wire [CW-1:0] tot_m1    = (pulse_total == {CW{1'b0}}) ? {CW{1'b0}} : pulse_total - 1'b1;

   // ****************************************
   // trigger and sample clock inputs
   // ****************************************
   cpg_edge_filter #(.W(NSRC), .SW(SW), .FW(16)) u_trig (
      .clk       (CLK),
      .nrst      (NRST),
      .pins      (TRIG_PIN),
      .sel       (ctrl[`CPG_TSRC_LSB+SW-1:`CPG_TSRC_LSB]),
      .filt_en   (trigger_filter_enable),
      .min_width (filt_width),
      .rise      (t_rise),
      .fall      (t_fall)
   );

   // sample clock is synchronised but never filtered
   cpg_edge_filter #(.W(NSRC), .SW(SW), .FW(16)) u_sclk (
      .clk       (CLK),
      .nrst      (NRST),
      .pins      (SCLK_PIN),
      .sel       (ctrl[`CPG_SSRC_LSB+SW-1:`CPG_SSRC_LSB]),
      .filt_en   (1'b0),
      .min_width (16'h0000),
      .rise      (s_rise),
      .fall      (s_fall)
   );

   wire trig_hit = ctrl[`CPG_TRIGEDGE_BIT] ? t_fall : t_rise; // see R07
   wire samp_hit = ctrl[`CPG_SCEDGE_BIT] ? s_fall : s_rise;

   // ****************************************
   // apb slave
   // ****************************************
   wire setup  = PSEL & ~PENABLE;
   wire wr     = PSEL & PENABLE & PWRITE & mapped(PADDR);
   wire buf_ok = ~running | (bmode == `CPG_BUF_LIVE); // see R15

   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped(PADDR);

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ctrl              <= `CPG_CTRL_RST;
         delay_a           <= {CW{1'b0}};
         high_duration     <= {{(CW-1){1'b0}}, 1'b1};
         low_duration      <= {{(CW-1){1'b0}}, 1'b1};
         pulse_total       <= {{(CW-1){1'b0}}, 1'b1};
         filt_width        <= 16'h0001;
         output_pin_select <= `CPG_PINSEL_RST;
         buf_len           <= {(AW+1){1'b0}};
         buf_wptr          <= {AW{1'b0}};
         buf_stage         <= {CW{1'b0}};
         start_cmd         <= 1'b0;
         stop_cmd          <= 1'b0;
      end else begin
         // commands act one cycle late so fields of the same write are in place
         start_cmd <= wr && (PADDR == `CPG_CTRL_OFS) && PWDATA[`CPG_START_BIT];
         stop_cmd  <= wr && (PADDR == `CPG_CTRL_OFS) && PWDATA[`CPG_STOP_BIT];
         if (wr) begin
            case (PADDR)
               `CPG_CTRL_OFS:   ctrl              <= PWDATA[`CPG_CTRL_MSB:0];
               `CPG_DELAY_OFS:  delay_a           <= PWDATA[CW-1:0];
               `CPG_HIGH_OFS:   high_duration     <= PWDATA[CW-1:0];
               `CPG_LOW_OFS:    low_duration      <= PWDATA[CW-1:0];
               `CPG_COUNT_OFS:  pulse_total       <= PWDATA[CW-1:0];
               `CPG_FILTER_OFS: filt_width        <= PWDATA[15:0];
               `CPG_PINSEL_OFS: output_pin_select <= PWDATA[7:0];
               `CPG_BUFLEN_OFS: if (buf_ok) buf_len <= (PWDATA[AW:0] > DEPTH) ? DEPTH[AW:0] : PWDATA[AW:0];
               `CPG_BUFPTR_OFS: if (buf_ok) buf_wptr <= PWDATA[AW-1:0];
               `CPG_BUFA_OFS:   buf_stage         <= PWDATA[CW-1:0];
               `CPG_BUFB_OFS:   if (buf_ok) buf_wptr <= buf_wptr + 1'b1;
               default: begin
               end
            endcase
         end
      end
   end

   // sample array has no reset, it is always written before use
   always @(posedge CLK) begin
      if (wr && (PADDR == `CPG_BUFB_OFS) && buf_ok) begin
         buf_a[buf_wptr] <= buf_stage;
         buf_b[buf_wptr] <= PWDATA[CW-1:0];
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         PRDATA <= 32'h00000000;
      end else if (setup) begin
         case (PADDR)
            `CPG_CTRL_OFS:   PRDATA <= {{(31-`CPG_CTRL_MSB){1'b0}}, ctrl[`CPG_CTRL_MSB:2], 2'b00};
            `CPG_DELAY_OFS:  PRDATA <= delay_a;
            `CPG_HIGH_OFS:   PRDATA <= high_duration;
            `CPG_LOW_OFS:    PRDATA <= low_duration;
            `CPG_COUNT_OFS:  PRDATA <= pulse_total;
            `CPG_FILTER_OFS: PRDATA <= {16'h0000, filt_width};
            `CPG_PINSEL_OFS: PRDATA <= {24'h000000, output_pin_select};
            `CPG_STATUS_OFS: PRDATA <= {{(15-AW){1'b0}}, rd_idx, 8'h00, pending, state, running};
            `CPG_PULSES_OFS: PRDATA <= pulses;
            `CPG_BUFLEN_OFS: PRDATA <= {{(31-AW){1'b0}}, buf_len};
            `CPG_BUFPTR_OFS: PRDATA <= {{(32-AW){1'b0}}, buf_wptr};
            `CPG_BUFA_OFS:   PRDATA <= buf_stage;
            default:         PRDATA <= 32'h00000000;
         endcase
      end
   end

   // ****************************************
   // next waveform sample
   // ****************************************
   always @* begin
      next_idle = cur_idle;
      next_act  = cur_act;
      next_idx  = rd_idx;
      next_stop = 1'b0;
      if (rd_idx < buf_len) begin // see R12
         next_idle = to_ticks(fmt, buf_a[rd_idx[AW-1:0]], buf_b[rd_idx[AW-1:0]], 1'b0);
         next_act  = to_ticks(fmt, buf_a[rd_idx[AW-1:0]], buf_b[rd_idx[AW-1:0]], 1'b1);
         next_idx  = rd_idx + 1'b1;
      end else if (bmode == `CPG_BUF_CYCLE && buf_len != {(AW+1){1'b0}}) begin
         next_idle = to_ticks(fmt, buf_a[0], buf_b[0], 1'b0); // see R15
         next_act  = to_ticks(fmt, buf_a[0], buf_b[0], 1'b1);
         next_idx  = {{AW{1'b0}}, 1'b1};
      end else if (bmode == `CPG_BUF_ONCE) begin
         next_stop = 1'b1;
      end
   end

   // ****************************************
   // pulse sequencer
   // ****************************************
   wire pulse_end = state[4] && (cnt == {CW{1'b0}});
   wire consume   = pulse_end && (mode == `CPG_MODE_VAR) && pending;

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state    <= ST_IDLE;
         cnt      <= {CW{1'b0}};
         pulses   <= {CW{1'b0}};
         cur_idle <= {{(CW-1){1'b0}}, 1'b1};
         cur_act  <= {{(CW-1){1'b0}}, 1'b1};
         rd_idx   <= {(AW+1){1'b0}};
         pending  <= 1'b0;
      end else begin
         // a sample edge in the cycle of consumption is kept for the next pulse
         pending <= (running && (mode == `CPG_MODE_VAR) && samp_hit) | (pending & ~consume);
         if (stop_cmd) begin
            state <= ST_IDLE; // see R06
         end else begin
            case (state)
               ST_IDLE: begin
                  if (start_cmd) begin
                     pulses   <= {CW{1'b0}};
                     rd_idx   <= {(AW+1){1'b0}};
                     cur_idle <= init_idle; // see R04
                     cur_act  <= init_act;
                     pending  <= 1'b0;
                     cnt      <= dly_ld;
                     state    <= trig_en ? ST_ARM : ST_DLY; // see R07
                  end
               end
               ST_ARM: begin
                  if (trig_hit) begin
                     cnt   <= dly_ld;
                     state <= ST_DLY;
                  end
               end
               ST_DLY: begin
                  if (cnt == {CW{1'b0}}) begin
                     cnt   <= cur_act - 1'b1; // see R02
                     state <= ST_ACT;
                  end else begin
                     cnt <= cnt - 1'b1;
                  end
               end
               ST_ACT: begin
                  if (cnt == {CW{1'b0}}) begin
                     cnt   <= cur_idle - 1'b1;
                     state <= ST_LOW;
                  end else begin
                     cnt <= cnt - 1'b1;
                  end
               end
               ST_LOW: begin
                  if (cnt == {CW{1'b0}}) begin
                     pulses <= pulses + 1'b1;
                     if (mode == `CPG_MODE_FINITE && pulses >= tot_m1) begin
                        state <= retrig ? ST_REARM : ST_IDLE; // see R05 R10
                     end else if (consume && next_stop) begin
                        state <= ST_IDLE;
                     end else if (consume) begin
                        cur_idle <= next_idle; // see R13
                        cur_act  <= next_act;
                        rd_idx   <= next_idx;
                        cnt      <= next_act - 1'b1;
                        state    <= ST_ACT;
                     end else begin
                        cnt   <= cur_act - 1'b1;
                        state <= ST_ACT;
                     end
                  end else begin
                     cnt <= cnt - 1'b1;
                  end
               end
               ST_REARM: begin
                  if (trig_hit) begin
                     pulses <= {CW{1'b0}};
                     if (delay_each_retrigger) begin
                        cnt   <= dly_ld; // see R11
                        state <= ST_DLY;
                     end else begin
                        cnt   <= cur_act - 1'b1;
                        state <= ST_ACT;
                     end
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************
   // output pins
   // ****************************************
   wire wave = state[3] ? ~idle_level : idle_level; // see R01

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
         always @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
               PIN_OUT[gi] <= 1'b0;
               PIN_OE[gi]  <= 1'b0;
            end else begin
               PIN_OE[gi]  <= (output_pin_select == gi); // see R16
               PIN_OUT[gi] <= (output_pin_select == gi) ? wave : 1'b0;
            end
         end
      end
   endgenerate
endmodule

// file: tb_counter_pulse_train_generator.sv
// self-checking bench of the pulse train generator
`timescale 1ns/1ns
`include "cpg_regs.vh"
module tb_counter_pulse_train_generator;
   logic        CLK = 1'b0;
   logic        NRST = 1'b0;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = '0;
   wire  [31:0] PRDATA;
   wire         PREADY;
   wire         PSLVERR;
   wire  [3:0]  TRIG_PIN;
   wire  [3:0]  SCLK_PIN;
   wire  [3:0]  PIN_OUT;
   wire  [3:0]  PIN_OE;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [31:0] m, h, base;
   logic [31:0] av[3] = '{32'd4, 32'd40, 32'd10000000};
   logic [31:0] bv[3] = '{32'd6, 32'd60, 32'd128};
   logic [31:0] hv[3] = '{32'd6, 32'd6, 32'd5};
   int          err_total = 0;
   int          tests_run = 0;
   int          pulses = 0;
   int          hi_len = 0;
   int          run_len = 0;
   logic        idle = 1'b0;
   wire         act = |(PIN_OUT & PIN_OE) ^ idle;
   cpg_top uut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG_PIN(TRIG_PIN),
      .SCLK_PIN(SCLK_PIN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
   cpg_pins u_pins (.trig(TRIG_PIN), .sclk(SCLK_PIN));
   always #20 CLK = ~CLK;
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one idle cycle between transfers keeps every signal to one assignment per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] k);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      if (!w) exp_q.push_back(d & k);
      if (!w) msk_q.push_back(k);
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      if (a > `CPG_BUFB_OFS) cmp("pslverr", 32'd1, {31'd0, PSLVERR});
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, '0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
      apb(1'b0, a, e, k);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge CLK);
   endtask
   always @(posedge CLK) begin
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && exp_q.size() > 0) begin
         m = msk_q.pop_front();
         cmp("prdata", exp_q.pop_front(), PRDATA & m);
      end
      if (act === 1'b1 && run_len == 0) pulses <= pulses + 1;
      if (act !== 1'b1 && run_len != 0) hi_len <= run_len;
      run_len <= (act === 1'b1) ? run_len + 1 : 0;
   end
   initial begin
      #400000;
      err_total++;
      conclude();
   end
   initial begin
      void'($urandom(32'h6703));
      repeat (5) @(posedge CLK);
      NRST <= 1'b1;
      rd(`CPG_CTRL_OFS, 32'h0, '1);
      rd(`CPG_HIGH_OFS, 32'h1, '1);
      rd(`CPG_LOW_OFS, 32'h1, '1);
      rd(`CPG_COUNT_OFS, 32'h1, '1);
      rd(`CPG_FILTER_OFS, 32'h1, '1);
      rd(`CPG_PINSEL_OFS, 32'h0, '1);
      rd(8'h40, 32'h0, '1);
      for (int i = 0; i < 2; i++) begin
         h = 2 + $urandom % 4;
         wr(`CPG_HIGH_OFS, h);
         wr(`CPG_LOW_OFS, 32'd3);
         wr(`CPG_COUNT_OFS, 32'd3);
         wr(`CPG_DELAY_OFS, i * 6);
         base = pulses;
         wr(`CPG_CTRL_OFS, 32'h1);
         cyc(60);
         cmp("pulses", base + 3, pulses);
         cmp("high", h, hi_len);
         rd(`CPG_PULSES_OFS, 32'd3, '1);
         rd(`CPG_STATUS_OFS, 32'h0, 32'h1);
         wr(`CPG_CTRL_OFS, 32'h2);
      end
      wr(`CPG_PINSEL_OFS, 32'd2);
      wr(`CPG_CTRL_OFS, 32'h4);
      idle <= 1'b1;
      cyc(4);
      base = pulses;
      wr(`CPG_CTRL_OFS, 32'h5);
      cyc(60);
      cmp("pin oe", 32'h4, PIN_OE);
      cmp("pulses", base + 3, pulses);
      cmp("idle out", 32'h4, PIN_OUT);
      wr(`CPG_CTRL_OFS, 32'h2);
      idle <= 1'b0;
      wr(`CPG_PINSEL_OFS, 32'd0);
      wr(`CPG_CTRL_OFS, 32'h9);
      cyc(80);
      rd(`CPG_STATUS_OFS, 32'h1, 32'h1);
      wr(`CPG_CTRL_OFS, 32'h2);
      rd(`CPG_STATUS_OFS, 32'h0, 32'h1);
      wr(`CPG_FILTER_OFS, 32'd3);
      wr(`CPG_COUNT_OFS, 32'd2);
      for (int e = 0; e < 2; e++) begin
         wr(`CPG_CTRL_OFS, 32'h81a1 | (e << 6) | (e << 9));
         base = pulses;
         u_pins.glitch(1, 40);
         cyc(20);
         cmp("glitch", base, pulses);
         u_pins.put(1, 1'b1);
         cyc(40);
         cmp("edge", base + (e ? 0 : 2), pulses);
         u_pins.put(1, 1'b0);
         cyc(40);
         cmp("edge", base + 2, pulses);
         u_pins.put(1, 1'b1);
         cyc(10);
         u_pins.put(1, 1'b0);
         cyc(40);
         cmp("retrigger", base + 4, pulses);
         wr(`CPG_CTRL_OFS, 32'h2);
      end
      for (int f = 0; f < 3; f++) begin
         wr(`CPG_BUFLEN_OFS, 32'd1);
         wr(`CPG_BUFPTR_OFS, 32'd0);
         wr(`CPG_BUFA_OFS, av[f]);
         wr(`CPG_BUFB_OFS, bv[f]);
         wr(`CPG_LOW_OFS, av[f]);
         wr(`CPG_CTRL_OFS, (f == 0 ? 32'h0011 : 32'h1011) | (f << 10));
         cyc(30);
         u_pins.tick(0);
         cyc(80);
         cmp("var high", hv[f], hi_len);
         if (f == 0) u_pins.tick(0);
         cyc(60);
         rd(`CPG_STATUS_OFS, (f == 0 ? 32'h0 : 32'h1), 32'h1);
         wr(`CPG_CTRL_OFS, 32'h2);
      end
      conclude();
   end
endmodule
